// [verilog/xcsv_defines.svh]
// Bit positions and widths of the control and status vectors, and the lane count
`ifndef XCSV_DEFINES_SVH
`define XCSV_DEFINES_SVH

`define XCSV_CTRL_W        7
`define XCSV_STAT_W        8
`define XCSV_CTRL_LOOPBACK 0
`define XCSV_CTRL_PWRDN    1
`define XCSV_CTRL_FLT_CLR  2
`define XCSV_CTRL_LNK_ARM  3
`define XCSV_CTRL_TEST_EN  4
`define XCSV_CTRL_SEL_LO   5
`define XCSV_CTRL_SEL_HI   6
`define XCSV_STAT_TX_FLT   0
`define XCSV_STAT_RX_FLT   1
`define XCSV_STAT_SYNC_LO  2
`define XCSV_STAT_SYNC_HI  5
`define XCSV_STAT_ALIGN    6
`define XCSV_STAT_LINK     7
`define XCSV_LANES         4

`endif

// [verilog/xcsv_pkg.sv]
// Types shared by the control and status vector block
`default_nettype none
package xcsv_pkg;
   typedef enum logic [1:0] {
      XCSV_PAT_HIGH  = 2'h0,
      XCSV_PAT_LOW   = 2'h1,
      XCSV_PAT_MIXED = 2'h2,
      XCSV_PAT_RSVD  = 2'h3
   } xcsv_pattern_type;
endpackage
`default_nettype wire

// [verilog/xcsv_latch.sv]
// Latching status bit with rising-edge clear
`default_nettype none
module xcsv_latch #(
   parameter bit LATCH_HIGH = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic live,
   input  wire logic clr_level,
   output logic      held
);
   logic clr_prev;
   logic clr_edge;

   assign clr_edge = clr_level & ~clr_prev;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clr_prev <= 1'b0;
      end else begin
         clr_prev <= clr_level;
      end
   end

   // Live condition wins over the clear, so an ongoing event is not lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         held <= ~LATCH_HIGH;
      end else if (LATCH_HIGH) begin
         held <= live | (held & ~clr_edge);
      end else begin
         held <= live & (held | clr_edge);
      end
   end
endmodule // xcsv_latch
`default_nettype wire

// [verilog/xcsv_vectors.sv]
// Control and status vector port of the four-lane link core
//
// Behaviour
// - Seven-bit control in, eight-bit status out
// - Control bits six-five pick test pattern
// - Codes: high, low, mixed, reserved
// - Control bit four enables pattern generation
// - Control bit one powers transceivers down
// - Control bit zero selects serial loopback
// - Status bit seven: link up, latches low
// - Rising control bit three re-arms link
// - Status bit six: all lanes aligned
// - Alignment output shares status bit six
// - Status bits five-two: per-lane sync
// - Sync output shares per-lane indications
// - Status bit one: receive fault, latches
// - Status bit zero: transmit fault, latches
// - Rising control bit two clears faults
`include "xcsv_defines.svh"
`default_nettype none
module xcsv_vectors
   import xcsv_pkg::*;
#(
   parameter int LANES = `XCSV_LANES
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [`XCSV_CTRL_W-1:0]   control_word,
   input  wire logic                      rx_link_up,
   input  wire logic                      rx_aligned,
   input  wire logic [LANES-1:0]          rx_lane_sync,
   input  wire logic                      rx_fault,
   input  wire logic                      tx_fault,
   output logic      [`XCSV_STAT_W-1:0]   status_word,
   output logic                           align_status,
   output logic      [LANES-1:0]          sync_status,
   output logic                           test_enable,
   output xcsv_pattern_type               test_select,
   output logic                           power_down,
   output logic                           loopback
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (LANES != `XCSV_LANES) begin : g_bad_lanes
      $error("status word holds exactly four lane sync bits");
   end

   logic link_held;
   logic rx_flt_held;
   logic tx_flt_held;
   logic aligned_q;
   logic [LANES-1:0] sync_q;

   // ------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------
   // Registered so downstream transceiver controls see clean levels
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         test_enable <= 1'b0;
         test_select <= XCSV_PAT_HIGH;
         power_down  <= 1'b0;
         loopback    <= 1'b0;
      end else begin
         test_enable <= control_word[`XCSV_CTRL_TEST_EN];
         test_select <= xcsv_pattern_type'(
            control_word[`XCSV_CTRL_SEL_HI:`XCSV_CTRL_SEL_LO]);
         power_down  <= control_word[`XCSV_CTRL_PWRDN];
         loopback    <= control_word[`XCSV_CTRL_LOOPBACK];
      end
   end

   // ------------------------------------------------------------
   // Latched status bits
   // ------------------------------------------------------------
   // clear inputs are same-domain flops, no synchroniser
   xcsv_latch #(.LATCH_HIGH(1'b0)) u_link (
      .clk       (clk),
      .rst_n     (rst_n),
      .live      (rx_link_up),
      .clr_level (control_word[`XCSV_CTRL_LNK_ARM]),
      .held      (link_held)
   );

   xcsv_latch #(.LATCH_HIGH(1'b1)) u_rx_flt (
      .clk       (clk),
      .rst_n     (rst_n),
      .live      (rx_fault),
      .clr_level (control_word[`XCSV_CTRL_FLT_CLR]),
      .held      (rx_flt_held)
   );

   xcsv_latch #(.LATCH_HIGH(1'b1)) u_tx_flt (
      .clk       (clk),
      .rst_n     (rst_n),
      .live      (tx_fault),
      .clr_level (control_word[`XCSV_CTRL_FLT_CLR]),
      .held      (tx_flt_held)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aligned_q <= 1'b0;
         sync_q    <= '0;
      end else begin
         aligned_q <= rx_aligned;
         sync_q    <= rx_lane_sync;
      end
   end

   // ------------------------------------------------------------
   // Status assembly
   // ------------------------------------------------------------
   // eight-bit status word
   assign status_word = {link_held, aligned_q, sync_q,
                         rx_flt_held, tx_flt_held};
   assign align_status = aligned_q;
   assign sync_status  = sync_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // A rising edge is a 0 sample followed by a 1 sample, matching the
   // edge detectors inside the latches; negated forms are written out
   // as plain expressions because a sequence cannot be negated
   sequence s_flt_rise;
      !$past(control_word[`XCSV_CTRL_FLT_CLR])
      && control_word[`XCSV_CTRL_FLT_CLR];
   endsequence

   sequence s_arm_rise;
      !$past(control_word[`XCSV_CTRL_LNK_ARM])
      && control_word[`XCSV_CTRL_LNK_ARM];
   endsequence

   chk_test_enable: assert property (
      @(posedge clk) disable iff (!rst_n)
      test_enable == $past(control_word[`XCSV_CTRL_TEST_EN]))
      else $error("test enable does not follow control bit");

   chk_test_select: assert property (
      @(posedge clk) disable iff (!rst_n)
      test_select == $past(control_word[6:5]))
      else $error("pattern select does not follow control bits");

   chk_power_down: assert property (
      @(posedge clk) disable iff (!rst_n)
      power_down == $past(control_word[`XCSV_CTRL_PWRDN]))
      else $error("power-down does not follow control bit");

   chk_loopback_bit: assert property (
      @(posedge clk) disable iff (!rst_n)
      loopback == $past(control_word[`XCSV_CTRL_LOOPBACK]))
      else $error("loopback does not follow control bit");

   chk_link_latch: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!status_word[7] && !(control_word[`XCSV_CTRL_LNK_ARM]
         && !$past(control_word[`XCSV_CTRL_LNK_ARM]))) |=> !status_word[7])
      else $error("link status left latched-low state");

   chk_link_rearm: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_arm_rise |=> status_word[7] == $past(rx_link_up))
      else $error("link status not re-armed");

   chk_align_same: assert property (
      @(posedge clk) disable iff (!rst_n)
      align_status == status_word[6]
      && status_word[6] == $past(rx_aligned))
      else $error("alignment output mismatch");

   chk_sync_same: assert property (
      @(posedge clk) disable iff (!rst_n)
      sync_status == status_word[5:2]
      && sync_status == $past(rx_lane_sync))
      else $error("lane sync output mismatch");

   chk_fault_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (status_word[1] && !(control_word[`XCSV_CTRL_FLT_CLR]
         && !$past(control_word[`XCSV_CTRL_FLT_CLR]))) |=> status_word[1])
      else $error("receive fault dropped without clear");

   chk_tx_fault_set: assert property (
      @(posedge clk) disable iff (!rst_n)
      tx_fault |=> status_word[0])
      else $error("transmit fault not latched");

   chk_fault_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s_flt_rise and (!rx_fault && !tx_fault))
         |=> status_word[1:0] == 2'h0)
      else $error("fault bits not cleared by edge");

   chk_fault_persist: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s_flt_rise and rx_fault) |=> status_word[1])
      else $error("persistent receive fault lost at clear");

   chk_tx_fault_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (status_word[0] && !(control_word[`XCSV_CTRL_FLT_CLR]
         && !$past(control_word[`XCSV_CTRL_FLT_CLR]))) |=> status_word[0])
      else $error("transmit fault dropped without clear");

   chk_tx_persist: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s_flt_rise and tx_fault) |=> status_word[0])
      else $error("persistent transmit fault lost at clear");
endmodule // xcsv_vectors
`default_nettype wire

// [sim/xcsv_user_model.sv]
// User logic model that registers the control word for the block
`default_nettype none
`include "xcsv_defines.svh"
module xcsv_user_model (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [`XCSV_CTRL_W-1:0] cw_req,
   output logic      [`XCSV_CTRL_W-1:0] control_word
);
   timeunit 1ns;
   timeprecision 100ps;
   // -------------------------------------------
   // Control register
   // -------------------------------------------
   // flop-driven control
   // One flop so clear and re-arm edges are glitch free in this domain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control_word <= '0;
      end else begin
         control_word <= cw_req;
      end
   end
endmodule // xcsv_user_model
`default_nettype wire

// [sim/xcsv_vectors_tb.sv]
// Self-checking bench for the control and status vector block
`default_nettype none
`include "xcsv_defines.svh"
module xcsv_vectors_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic [`XCSV_CTRL_W-1:0] cw_req = '0;
   logic [`XCSV_CTRL_W-1:0] control_word;
   logic                    rx_link_up = 1'b0;
   logic                    rx_aligned = 1'b0;
   logic                    rx_fault = 1'b0;
   logic                    tx_fault = 1'b0;
   logic [3:0]              rx_lane_sync = 4'h0;
   logic [7:0]              status_word;
   logic                    align_status;
   logic [3:0]              sync_status;
   logic                    test_enable;
   logic                    power_down;
   logic                    loopback;
   xcsv_pkg::xcsv_pattern_type test_select;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   xcsv_user_model u_user (.clk(clk), .rst_n(rst_n), .cw_req(cw_req),
      .control_word(control_word));
   xcsv_vectors u_dut (.clk(clk), .rst_n(rst_n),
      .control_word(control_word), .rx_link_up(rx_link_up),
      .rx_aligned(rx_aligned), .rx_lane_sync(rx_lane_sync),
      .rx_fault(rx_fault), .tx_fault(tx_fault),
      .status_word(status_word), .align_status(align_status),
      .sync_status(sync_status), .test_enable(test_enable),
      .test_select(test_select), .power_down(power_down),
      .loopback(loopback));

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({7'h0, got}, {7'h0, exp});
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // -------------------------------------------
   // Scenarios
   // -------------------------------------------
   task automatic t_ctrl();
      for (int i = 0; i < 4; i++) begin
         cw_req = {i[1:0], i[0], 2'h0, ~i[0], i[1]};
         step(2);
         chk({3'h0, test_select, test_enable, power_down, loopback},
             {3'h0, i[1:0], i[0], ~i[0], i[1]});
      end
   endtask

   task automatic t_lanes();
      for (int i = 0; i < 16; i += 5) begin
         rx_lane_sync = i[3:0];
         rx_aligned = i[0];
         step(1);
         chk({3'h0, status_word[6:2]}, {3'h0, i[0], i[3:0]});
         chk({3'h0, align_status, sync_status},
             {3'h0, i[0], i[3:0]});
      end
   endtask

   task automatic t_link();
      rx_link_up = 1'b1;
      step(2);
      chk1(status_word[7], 1'b0);
      cw_req[3] = 1'b1;
      step(2);
      chk1(status_word[7], 1'b1);
      cw_req[3] = 1'b0;
      rx_link_up = 1'b0;
      step(1);
      chk1(status_word[7], 1'b0);
      rx_link_up = 1'b1;
      step(2);
      chk1(status_word[7], 1'b0);
      cw_req[3] = 1'b1;
      step(2);
      chk1(status_word[7], 1'b1);
      cw_req[3] = 1'b0;
   endtask

   task automatic t_fault();
      tx_fault = 1'b1;
      step(1);
      chk({6'h0, status_word[1:0]}, 8'h1);
      tx_fault = 1'b0;
      rx_fault = 1'b1;
      step(1);
      chk({6'h0, status_word[1:0]}, 8'h3);
      rx_fault = 1'b0;
      step(3);
      chk({6'h0, status_word[1:0]}, 8'h3);
      cw_req[2] = 1'b1;
      step(2);
      chk({6'h0, status_word[1:0]}, 8'h0);
      // Fault still live across a fresh clear edge must win
      rx_fault = 1'b1;
      tx_fault = 1'b1;
      cw_req[2] = 1'b0;
      step(2);
      cw_req[2] = 1'b1;
      step(2);
      chk({6'h0, status_word[1:0]}, 8'h3);
      rx_fault = 1'b0;
      tx_fault = 1'b0;
      cw_req[2] = 1'b0;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      step(1);
      chk(status_word, 8'h0);
      t_ctrl();
      t_lanes();
      t_link();
      t_fault();
      tally_and_finish();
   end
endmodule // xcsv_vectors_tb
`default_nettype wire
